// ### core/i2sr_pkg.sv
// Constants shared by the status, clock, data and own-address block.
package i2sr_pkg;
   // ==========================================================
   // Register indices; byte address is four times the index.
   // ==========================================================
   localparam logic [7:0] IDX_STATUS_PRIMARY = 8'h5e;
   localparam logic [7:0] IDX_STATUS_ERRORS  = 8'h5d;
   localparam logic [7:0] IDX_BUS_CLOCK_CTRL = 8'h5c;
   localparam logic [7:0] IDX_OWN_SLAVE_ADDR = 8'h5b;
   localparam logic [7:0] IDX_BYTE_BUFFER    = 8'h59;

   // ==========================================================
   // Field positions of status_primary.
   // ==========================================================
   localparam int SP_EVENT   = 7;
   localparam int SP_DIR     = 5;
   localparam int SP_BUSY    = 4;
   localparam int SP_BYTE    = 3;
   localparam int SP_ADDR    = 2;
   localparam int SP_MASTER  = 1;
   localparam int SP_START   = 0;

   // ==========================================================
   // Field positions of status_errors.
   // ==========================================================
   localparam int SE_ACKFAIL = 4;
   localparam int SE_STOP    = 3;
   localparam int SE_ARB     = 2;
   localparam int SE_BUSERR  = 1;
   localparam int SE_GCALL   = 0;

   // ==========================================================
   // Clock control and address fields, reset values.
   // ==========================================================
   localparam int         CC_SPEED_BIT    = 7;
   localparam logic [7:0] CC_DIV_OFFSET   = 8'h02;
   localparam logic [7:0] ADDR_IGNORED    = 8'h01;
   localparam logic [7:0] ADDR_GENERAL    = 8'h00;
   localparam logic [7:0] RESET_REG       = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
   localparam logic       HRESP_OKAY      = 1'h0;
endpackage : i2sr_pkg

// ### core/i2sr_status_regs.sv
// Status flags, bus clock divider, byte buffer and own address behind AHB-Lite.
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module i2sr_status_regs (
   input  wire logic        mclk,
   input  wire logic        reset,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Control register bits and strobes.
   input  wire logic        peripheralEnable,
   input  wire logic        generalCallEnable,
   input  wire logic        interruptEnable,
   input  wire logic        ackEnable,
   input  wire logic        startRequest,
   input  wire logic        controlWrite,
   // Events from the transfer sequencer and bus condition detector.
   input  wire logic        startDetected,
   input  wire logic        stopDetected,
   input  wire logic        startSent,
   input  wire logic        addressComplete,
   input  wire logic        byteSent,
   input  wire logic        byteReceived,
   input  wire logic [7:0]  receivedByte,
   input  wire logic        addressReceived,
   input  wire logic [7:0]  addressByte,
   input  wire logic        ackMissing,
   input  wire logic        arbitrationLost,
   input  wire logic        misplacedCondition,
   input  wire logic        transmitterMode,
   // Outputs to the sequencer and the system.
   output logic             sclHoldLow,
   output logic             busClock,
   output logic             addressAck,
   output logic             txStart,
   output logic [7:0]       txByte,
   output logic             rxNext,
   output logic             irq
);

   // ==========================================================
   // Helpers.
   // ==========================================================
   function automatic logic regHit(input logic [31:0] addr, input logic [7:0] idx);
      regHit = (addr[31:10] == 22'h0) && (addr[9:2] == idx);
   endfunction

   // ==========================================================
   // Bus slave.
   // ==========================================================
   logic       accept;
   logic       wrPend;
   logic [7:0] wrIdx;
   logic       readPrimary;
   logic       readErrors;
   logic       readBuffer;
   logic       writeBuffer;
   logic       writeClock;
   logic       writeAddress;
   logic       primaryArmed;

   logic       summaryEventFlag;
   logic       directionFlag;
   logic       busBusy;
   logic       byteDoneFlag;
   logic       addressMatchFlag;
   logic       masterSelectFlag;
   logic       startSentFlag;
   logic       addrCompletePending;
   logic       ackFailureFlag;
   logic       stopSeenFlag;
   logic       arbitrationLostFlag;
   logic       busErrorFlag;
   logic       generalCallFlag;
   logic [7:0] busClockControl;
   logic [7:0] byteBuffer;
   logic [7:0] ownSlaveAddress;
   logic [7:0] statusPrimary;
   logic [7:0] statusErrors;
   logic       ownMatch;
   logic       generalMatch;
   logic       pe;

   assign pe        = peripheralEnable;
   assign hreadyout = 1'b1;
   assign hresp     = i2sr_pkg::HRESP_OKAY;
   assign accept    = hsel && hready && (htrans == i2sr_pkg::HTRANS_NONSEQ);

   // Read side effects happen when the read address is taken.
   assign readPrimary  = accept && !hwrite && regHit(haddr, i2sr_pkg::IDX_STATUS_PRIMARY);
   assign readErrors   = accept && !hwrite && regHit(haddr, i2sr_pkg::IDX_STATUS_ERRORS);
   assign readBuffer   = accept && !hwrite && regHit(haddr, i2sr_pkg::IDX_BYTE_BUFFER);
   assign writeBuffer  = wrPend && (wrIdx == i2sr_pkg::IDX_BYTE_BUFFER);
   assign writeClock   = wrPend && (wrIdx == i2sr_pkg::IDX_BUS_CLOCK_CTRL);
   assign writeAddress = wrPend && (wrIdx == i2sr_pkg::IDX_OWN_SLAVE_ADDR);

   always_ff @(posedge mclk) begin
      if (reset) begin
         wrPend <= 1'b0;
         wrIdx  <= 8'h00;
      end else begin
         wrPend <= accept && hwrite && (haddr[31:10] == 22'h0);
         wrIdx  <= haddr[9:2];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
      end else if (accept && !hwrite) begin
         if (regHit(haddr, i2sr_pkg::IDX_STATUS_PRIMARY)) begin
            hrdata <= {24'h00_0000, statusPrimary};
         end else if (regHit(haddr, i2sr_pkg::IDX_STATUS_ERRORS)) begin
            hrdata <= {24'h00_0000, statusErrors};
         end else if (regHit(haddr, i2sr_pkg::IDX_BUS_CLOCK_CTRL)) begin
            hrdata <= {24'h00_0000, busClockControl};
         end else if (regHit(haddr, i2sr_pkg::IDX_OWN_SLAVE_ADDR)) begin
            hrdata <= {24'h00_0000, ownSlaveAddress};
         end else if (regHit(haddr, i2sr_pkg::IDX_BYTE_BUFFER)) begin
            hrdata <= {24'h00_0000, byteBuffer};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // A primary status read arms the clear; the following data or control access consumes it.
   always_ff @(posedge mclk) begin
      if (reset || !pe) begin
         primaryArmed <= 1'b0;
      end else if (readPrimary) begin
         primaryArmed <= 1'b1;
      end else if (readBuffer || writeBuffer || controlWrite) begin
         primaryArmed <= 1'b0;
      end
   end

   // ==========================================================
   // Status composition.
   // ==========================================================
   assign summaryEventFlag = byteDoneFlag | addressMatchFlag | startSentFlag
                           | addrCompletePending | ackFailureFlag | stopSeenFlag
                           | arbitrationLostFlag | busErrorFlag;

   always_comb begin
      statusPrimary                          = i2sr_pkg::RESET_REG;
      statusPrimary[i2sr_pkg::SP_EVENT]      = summaryEventFlag;
      statusPrimary[i2sr_pkg::SP_DIR]        = directionFlag;
      statusPrimary[i2sr_pkg::SP_BUSY]       = busBusy;
      statusPrimary[i2sr_pkg::SP_BYTE]       = byteDoneFlag;
      statusPrimary[i2sr_pkg::SP_ADDR]       = addressMatchFlag;
      statusPrimary[i2sr_pkg::SP_MASTER]     = masterSelectFlag;
      statusPrimary[i2sr_pkg::SP_START]      = startSentFlag;
      statusErrors                           = i2sr_pkg::RESET_REG;
      statusErrors[i2sr_pkg::SE_ACKFAIL]     = ackFailureFlag;
      statusErrors[i2sr_pkg::SE_STOP]        = stopSeenFlag;
      statusErrors[i2sr_pkg::SE_ARB]         = arbitrationLostFlag;
      statusErrors[i2sr_pkg::SE_BUSERR]      = busErrorFlag;
      statusErrors[i2sr_pkg::SE_GCALL]       = generalCallFlag;
   end

   // ==========================================================
   // Event flags. Every set wins over a clear in the same cycle.
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (reset) begin
         busBusy <= 1'b0;
      end else if (startDetected) begin
         busBusy <= 1'b1;
      end else if (stopDetected) begin
         busBusy <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || !pe) begin
         byteDoneFlag  <= 1'b0;
         directionFlag <= 1'b0;
      end else if (byteSent) begin
         byteDoneFlag  <= 1'b1;
         directionFlag <= 1'b1;
      end else if (byteReceived) begin
         byteDoneFlag  <= 1'b1;
         directionFlag <= 1'b0;
      end else if (primaryArmed && ((directionFlag && writeBuffer)
                                 || (!directionFlag && readBuffer))) begin
         byteDoneFlag  <= 1'b0;
         directionFlag <= 1'b0;
      end else if (stopDetected || arbitrationLost) begin
         directionFlag <= 1'b0;
      end
   end

   // Address 01h is never matched; the general call needs its enable.
   assign generalMatch = generalCallEnable && (addressByte == i2sr_pkg::ADDR_GENERAL);
   assign ownMatch     = (addressByte[7:1] == ownSlaveAddress[7:1])
                       && (addressByte != i2sr_pkg::ADDR_IGNORED);

   always_ff @(posedge mclk) begin
      if (reset || !pe) begin
         addressMatchFlag <= 1'b0;
         generalCallFlag  <= 1'b0;
         addressAck       <= 1'b0;
      end else begin
         addressAck <= addressReceived && !masterSelectFlag && ackEnable
                     && (ownMatch || generalMatch);
         if (addressReceived && !masterSelectFlag && ackEnable && (ownMatch || generalMatch)) begin
            addressMatchFlag <= 1'b1;
         end else if (readPrimary) begin
            addressMatchFlag <= 1'b0;
         end
         if (addressReceived && !masterSelectFlag && generalMatch) begin
            generalCallFlag <= 1'b1;
         end else if (stopDetected) begin
            generalCallFlag <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || !pe) begin
         masterSelectFlag <= 1'b0;
      end else if (startRequest) begin
         masterSelectFlag <= 1'b1;
      end else if (stopDetected || arbitrationLost) begin
         masterSelectFlag <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || !pe) begin
         startSentFlag       <= 1'b0;
         addrCompletePending <= 1'b0;
      end else begin
         if (startSent) begin
            startSentFlag <= 1'b1;
         end else if (primaryArmed && writeBuffer) begin
            startSentFlag <= 1'b0;
         end
         if (addressComplete && masterSelectFlag) begin
            addrCompletePending <= 1'b1;
         end else if (primaryArmed && controlWrite) begin
            addrCompletePending <= 1'b0;
         end
      end
   end

   // Error flags clear on a read of the error status register.
   always_ff @(posedge mclk) begin
      if (reset || !pe) begin
         ackFailureFlag      <= 1'b0;
         stopSeenFlag        <= 1'b0;
         arbitrationLostFlag <= 1'b0;
         busErrorFlag        <= 1'b0;
      end else begin
         ackFailureFlag      <= ackMissing || (ackFailureFlag && !readErrors);
         stopSeenFlag        <= (stopDetected && ackEnable && !masterSelectFlag)
                              || (stopSeenFlag && !readErrors);
         arbitrationLostFlag <= arbitrationLost || (arbitrationLostFlag && !readErrors);
         busErrorFlag        <= misplacedCondition || (busErrorFlag && !readErrors);
      end
   end

   // Error flags deliberately do not hold the clock: software must free the lines.
   assign sclHoldLow = byteDoneFlag | addressMatchFlag | startSentFlag
                     | addrCompletePending;
   assign irq        = summaryEventFlag && interruptEnable && pe;

   // ==========================================================
   // Software registers; none is touched by disable.
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (reset) begin
         busClockControl <= i2sr_pkg::RESET_REG;
         ownSlaveAddress <= i2sr_pkg::RESET_REG;
      end else begin
         if (writeClock) begin
            busClockControl <= hwdata[7:0];
         end
         if (writeAddress) begin
            ownSlaveAddress <= hwdata[7:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         byteBuffer <= i2sr_pkg::RESET_REG;
         txStart    <= 1'b0;
         txByte     <= 8'h00;
         rxNext     <= 1'b0;
      end else begin
         if (writeBuffer) begin
            byteBuffer <= hwdata[7:0];
         end else if (byteReceived) begin
            byteBuffer <= receivedByte;
         end
         txStart <= writeBuffer && transmitterMode && pe;
         if (writeBuffer) begin
            txByte <= hwdata[7:0];
         end
         rxNext <= readBuffer && !transmitterMode && pe;
      end
   end

   // ==========================================================
   // Bus clock divider: high then low phase of (divider+2) each in
   // standard mode, low phase doubled in fast mode.
   // ==========================================================
   logic [8:0] divCount;
   logic [8:0] halfLen;
   logic [8:0] phaseLen;

   assign halfLen  = {2'b00, busClockControl[6:0]} + {1'b0, i2sr_pkg::CC_DIV_OFFSET};
   assign phaseLen = (busClockControl[i2sr_pkg::CC_SPEED_BIT] && !busClock)
                   ? {halfLen[7:0], 1'b0} : halfLen;

   always_ff @(posedge mclk) begin
      if (reset || !pe) begin
         divCount <= 9'h000;
         busClock <= 1'b1;
      end else if (divCount >= phaseLen - 9'h001) begin
         divCount <= 9'h000;
         busClock <= !busClock;
      end else begin
         divCount <= divCount + 9'h001;
      end
   end

   // ==========================================================
   // Checks.
   // ==========================================================
   summary_event_a: assert property (@(posedge mclk) disable iff (reset)
      (pe && (byteSent || startSent || ackMissing)) |=> summaryEventFlag)
      else $error("summary event flag not raised by an event");

   error_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (ackFailureFlag && readErrors && !ackMissing) |=> !ackFailureFlag)
      else $error("ack failure not cleared by error status read");

   busy_track_a: assert property (@(posedge mclk) disable iff (reset)
      startDetected |=> busBusy)
      else $error("bus busy not set by start");

   tx_done_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (pe && byteDoneFlag && directionFlag && primaryArmed && writeBuffer
       && !byteSent && !byteReceived) |=> !byteDoneFlag && !directionFlag)
      else $error("transmit byte-done not cleared by data write");

   start_sent_a: assert property (@(posedge mclk) disable iff (reset)
      (pe && startSent) |=> startSentFlag ##0 sclHoldLow)
      else $error("start sent flag or clock hold missing");

   disable_clear_a: assert property (@(posedge mclk) disable iff (reset)
      !pe |=> !summaryEventFlag && !masterSelectFlag && !generalCallFlag)
      else $error("flags not cleared while disabled");

   address_ignore_a: assert property (@(posedge mclk) disable iff (reset)
      (addressReceived && addressByte == i2sr_pkg::ADDR_IGNORED) |=> !addressAck)
      else $error("address 01h was matched");

   tx_launch_a: assert property (@(posedge mclk) disable iff (reset)
      (writeBuffer && transmitterMode && pe) |=> txStart && (txByte == $past(hwdata[7:0])))
      else $error("data write did not launch transmission");

   irq_gate_a: assert property (@(posedge mclk) disable iff (reset)
      irq |-> summaryEventFlag && interruptEnable)
      else $error("interrupt without enabled event");

   arb_slave_a: assert property (@(posedge mclk) disable iff (reset)
      (pe && arbitrationLost && !startRequest) |=> !masterSelectFlag && arbitrationLostFlag)
      else $error("arbitration loss did not return to slave");

endmodule // i2sr_status_regs

// ### bench/i2sr_bus_peer.sv
// Far bus side model: produces bus condition and byte events.
`timescale 1ns/1ps
module i2sr_bus_peer (
   input  wire logic       mclk,
   output logic      [9:0] evPulse,
   output logic      [7:0] evData
);
   initial begin
      evPulse = 10'h000;
      evData  = 8'h00;
   end
   // The byte is inverted once the event is gone, so stale data never looks fresh.
   task automatic fire(input int b, input logic [7:0] v);
      @(posedge mclk);
      evPulse[b] <= 1'b1;
      evData     <= v;
      @(posedge mclk);
      evPulse    <= 10'h000;
      evData     <= ~v;
   endtask
endmodule // i2sr_bus_peer

// ### bench/tb.sv
// Self-checking bench for the status, clock, data and own-address block.
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] SP = i2sr_pkg::IDX_STATUS_PRIMARY;
   localparam logic [7:0] SE = i2sr_pkg::IDX_STATUS_ERRORS;
   localparam logic [7:0] CC = i2sr_pkg::IDX_BUS_CLOCK_CTRL;
   localparam logic [7:0] OA = i2sr_pkg::IDX_OWN_SLAVE_ADDR;
   localparam logic [7:0] DB = i2sr_pkg::IDX_BYTE_BUFFER;
   logic        mclk, reset, hsel, hwrite, hreadyout, hresp, sclHoldLow, busClock;
   logic        peripheralEnable, generalCallEnable, interruptEnable, ackEnable;
   logic        transmitterMode, addressAck, txStart, rxNext, irq;
   logic [1:0]  htrans, swPulse;
   logic [7:0]  txByte, evData;
   logic [9:0]  evPulse;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  regs [6] = '{SP, SE, CC, OA, DB, 8'h00};
   int          err_total, num_checks, txSeen, rxSeen, ackSeen, n;

   i2sr_bus_peer bus (.mclk(mclk), .evPulse(evPulse), .evData(evData));
   i2sr_status_regs DUT (
      .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .peripheralEnable(peripheralEnable), .generalCallEnable(generalCallEnable),
      .interruptEnable(interruptEnable), .ackEnable(ackEnable),
      .startRequest(swPulse[0]), .controlWrite(swPulse[1]),
      .startDetected(evPulse[0]), .stopDetected(evPulse[1]), .startSent(evPulse[2]),
      .addressComplete(evPulse[3]), .byteSent(evPulse[4]), .byteReceived(evPulse[5]),
      .receivedByte(evData), .addressReceived(evPulse[6]), .addressByte(evData),
      .ackMissing(evPulse[7]), .arbitrationLost(evPulse[8]),
      .misplacedCondition(evPulse[9]), .transmitterMode(transmitterMode),
      .sclHoldLow(sclHoldLow), .busClock(busClock), .addressAck(addressAck),
      .txStart(txStart), .txByte(txByte), .rxNext(rxNext), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #300000;
      err_total++;
      final_report();
   end
   always @(posedge mclk) begin
      txSeen  <= txSeen + int'(txStart === 1'b1);
      rxSeen  <= rxSeen + int'(rxNext === 1'b1);
      ackSeen <= ackSeen + int'(addressAck === 1'b1);
   end

   // ==========================================================
   // Bus and comparison tasks
   // ==========================================================
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // The slave never stretches today, but the master still waits on hready.
   task automatic waitRdy();
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 64);
      if (k >= 64) begin
         err_total++;
         final_report();
      end
   endtask
   task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] v,
                       output logic [31:0] r);
      @(posedge mclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= i2sr_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      waitRdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, v};
      waitRdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] r;
      xfer(idx, 1'b1, v, r);
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] r;
      xfer(idx, 1'b0, 8'h00, r);
      chk($sformatf("reg %h", idx), {24'h0, e}, r);
   endtask
   task automatic sw(input int b);
      @(posedge mclk);
      swPulse[b] <= 1'b1;
      @(posedge mclk);
      swPulse    <= 2'h0;
   endtask
   // Skips the first bus clock period so a divider change in flight is not measured.
   task automatic period(output int p);
      logic prev;
      int   r;
      prev = busClock;
      r = 0;
      p = 0;
      for (int g = 0; g < 3000 && r < 3; g++) begin
         @(posedge mclk);
         if (r > 1)
            p++;
         if (busClock === 1'b1 && prev === 1'b0)
            r++;
         prev = busClock;
      end
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, swPulse} = '0;
      {peripheralEnable, generalCallEnable, interruptEnable, ackEnable} = 4'h0;
      transmitterMode = 1'b0;
      reset = 1'b1;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      foreach (regs[i]) rdChk(regs[i], 8'h00);
      chk("hresp", i2sr_pkg::HRESP_OKAY, hresp);
      bus.fire(0, 8'h00);
      rdChk(SP, 8'h10);
      bus.fire(1, 8'h00);
      rdChk(SP, 8'h00);
      @(posedge mclk);
      peripheralEnable <= 1'b1;
      interruptEnable  <= 1'b1;
      ackEnable        <= 1'b1;
      transmitterMode  <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         wr(CC, {i[0], 7'h03});
         rdChk(CC, {i[0], 7'h03});
         period(n);
         chk("period", (3 + 2) * (i ? 3 : 2), n);
      end
      bus.fire(4, 8'h00);
      @(negedge mclk);
      chk("sclHoldLow", 1, sclHoldLow);
      chk("irq", 1, irq);
      rdChk(SP, 8'ha8);
      wr(DB, 8'h5a);
      rdChk(SP, 8'h00);
      chk("txByte", 8'h5a, txByte);
      chk("txStart", 1, txSeen);
      transmitterMode <= 1'b0;
      n = rxSeen;
      bus.fire(5, 8'h3c);
      rdChk(SP, 8'h88);
      rdChk(DB, 8'h3c);
      rdChk(SP, 8'h00);
      chk("rxNext", n + 1, rxSeen);
      wr(OA, 8'ha4);
      rdChk(OA, 8'ha4);
      bus.fire(6, 8'ha5);
      @(negedge mclk);
      chk("sclHoldLow", 1, sclHoldLow);
      rdChk(SP, 8'h84);
      chk("addressAck", 1, ackSeen);
      rdChk(SP, 8'h00);
      wr(OA, 8'h00);
      bus.fire(6, 8'h01);
      rdChk(SP, 8'h00);
      generalCallEnable <= 1'b1;
      bus.fire(6, 8'h00);
      rdChk(SE, 8'h01);
      rdChk(SP, 8'h84);
      bus.fire(1, 8'h00);
      rdChk(SP, 8'h80);
      rdChk(SE, 8'h08);
      rdChk(SE, 8'h00);
      for (int i = 7; i < 10; i++) begin
         if (i == 8) begin
            sw(0);
            rdChk(SP, 8'h02);
         end
         bus.fire(i, 8'h00);
         @(negedge mclk);
         chk("sclHoldLow", 0, sclHoldLow);
         rdChk(SP, 8'h80);
         rdChk(SE, i == 7 ? 8'h10 : 8'h08 >> (i - 7));
         rdChk(SE, 8'h00);
         rdChk(SP, 8'h00);
      end
      ackEnable       <= 1'b0;
      interruptEnable <= 1'b0;
      sw(0);
      bus.fire(2, 8'h00);
      rdChk(SP, 8'h83);
      wr(DB, 8'ha4);
      rdChk(SP, 8'h02);
      bus.fire(3, 8'h00);
      @(negedge mclk);
      chk("sclHoldLow", 1, sclHoldLow);
      chk("irq", 0, irq);
      rdChk(SP, 8'h82);
      sw(1);
      rdChk(SP, 8'h02);
      bus.fire(1, 8'h00);
      rdChk(SP, 8'h00);
      wr(OA, 8'h7e);
      transmitterMode <= 1'b1;
      bus.fire(0, 8'h00);
      bus.fire(4, 8'h00);
      peripheralEnable <= 1'b0;
      rdChk(SP, 8'h10);
      rdChk(CC, 8'h83);
      rdChk(OA, 8'h7e);
      bus.fire(1, 8'h00);
      rdChk(SP, 8'h00);
      chk("busClock", 1, busClock);
      // A second reset in mid-run must bring clock control and own address back to zero.
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rdChk(CC, 8'h00);
      rdChk(OA, 8'h00);
      rdChk(SP, 8'h00);
      final_report();
   end
endmodule // tb
